/* core/receiver_config_regs.sv */
// Receiver configuration register bank with AHB-Lite slave and squelch/gain sequencing.
//
// Register access over AHB-Lite was chosen for this implementation.
`timescale 1ns/1ps
module receiver_config_regs #(
	parameter int SQUELCH_DELAY = receiver_config_pkg::SQUELCH_DELAY_CYCLES,
	parameter int PULSE_LIMIT   = receiver_config_pkg::GAIN_PULSE_LIMIT
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        tx_end_pulse,
	input  wire logic [7:0]  mask_receive_timer,
	input  wire logic [7:0]  squelch_time,
	input  wire logic        receive_active,
	input  wire logic        subcarrier_pulse_pin,
	output logic             receive_channel_pick,
	output logic      [2:0]  lowpass_filter_field,
	output logic             zero_setting_bit_high,
	output logic             zero_setting_bit_mid_high,
	output logic             zero_setting_bit_mid_low,
	output logic             zero_setting_bit_low,
	output logic             demod_iq_select,
	output logic             amplitude_demod_mixer,
	output logic             squelch_dynamic_enable,
	output logic             squelch_ratio_high,
	output logic             gain_loop_enable,
	output logic             gain_loop_full_period,
	output logic             gain_loop_reset_algorithm,
	output logic             gain_loop_trigger_ratio,
	output logic      [2:0]  amplitude_first_stage_gain,
	output logic      [2:0]  phase_first_stage_gain,
	output logic             low_frequency_input_enable,
	output logic             low_frequency_split_select,
	output logic             squelch_active,
	output logic             gain_loop_active
);
	import receiver_config_pkg::*;

	// ------------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------------
	function automatic reg_select_t decode_address(input logic [31:0] addr);
		reg_select_t sel;
		case (addr)
			FILTER_CHANNEL_ADDR: sel = SEL_FILTER_CHANNEL;
			DEMOD_SQUELCH_ADDR:  sel = SEL_DEMOD_SQUELCH;
			FIRST_STAGE_ADDR:    sel = SEL_FIRST_STAGE;
			default:             sel = SEL_NONE;
		endcase
		return sel;
	endfunction : decode_address

	logic [7:0]  filter_channel;
	logic [7:0]  demod_squelch;
	logic [7:0]  first_stage;
	logic [7:0]  next_filter_channel;
	logic [7:0]  next_demod_squelch;
	logic [7:0]  next_first_stage;
	logic        write_pending;
	reg_select_t write_select;
	logic        next_write_pending;
	reg_select_t next_write_select;
	logic [31:0] next_hrdata;
	logic        address_phase;
	reg_select_t address_select;

	// ------------------------------------------------------------------
	// Bus slave
	// ------------------------------------------------------------------
	// The slave never stretches a transfer, so a write lands at the end of
	// its data phase and a read issued right behind it must see hwdata.
	always_comb begin
		address_phase       = hsel && htrans[1] && hready;
		address_select      = decode_address(haddr);
		next_write_pending  = 1'b0;
		next_write_select   = SEL_NONE;
		next_hrdata         = hrdata;
		next_filter_channel = filter_channel;
		next_demod_squelch  = demod_squelch;
		next_first_stage    = first_stage;
		if (write_pending) begin
			case (write_select)
				SEL_FILTER_CHANNEL: next_filter_channel = hwdata[7:0];
				SEL_DEMOD_SQUELCH:  next_demod_squelch  = hwdata[7:0];
				SEL_FIRST_STAGE:    next_first_stage    = hwdata[7:0];
				default:            next_first_stage    = first_stage;
			endcase
		end
		if (address_phase) begin
			if (hwrite) begin
				next_write_pending = (address_select != SEL_NONE);
				next_write_select  = address_select;
			end else begin
				case (address_select)
					SEL_FILTER_CHANNEL: next_hrdata = {24'h00_0000, next_filter_channel};
					SEL_DEMOD_SQUELCH:  next_hrdata = {24'h00_0000, next_demod_squelch};
					SEL_FIRST_STAGE:    next_hrdata = {24'h00_0000, next_first_stage};
					default:            next_hrdata = 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			filter_channel <= FILTER_CHANNEL_RESET;
			demod_squelch  <= DEMOD_SQUELCH_RESET;
			first_stage    <= FIRST_STAGE_RESET;
			write_pending  <= 1'b0;
			write_select   <= SEL_NONE;
			hrdata         <= 32'h0000_0000;
			hreadyout      <= 1'b0;
			hresp          <= 1'b0;
		end else begin
			filter_channel <= next_filter_channel;
			demod_squelch  <= next_demod_squelch;
			first_stage    <= next_first_stage;
			write_pending  <= next_write_pending;
			write_select   <= next_write_select;
			hrdata         <= next_hrdata;
			hreadyout      <= 1'b1;
			hresp          <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// Field outputs
	// ------------------------------------------------------------------
	// Software must pair I/Q demodulation with the mixer; the bank stores
	// whatever is written and does not correct a bad pairing.
	assign receive_channel_pick       = filter_channel[CHANNEL_PICK_BIT];
	assign lowpass_filter_field       = filter_channel[LOWPASS_MSB:LOWPASS_LSB];
	assign zero_setting_bit_high      = filter_channel[ZERO_HIGH_BIT];
	assign zero_setting_bit_mid_high  = filter_channel[ZERO_MID_HIGH_BIT];
	assign zero_setting_bit_mid_low   = filter_channel[ZERO_MID_LOW_BIT];
	assign zero_setting_bit_low       = filter_channel[ZERO_LOW_BIT];
	assign demod_iq_select            = demod_squelch[DEMOD_IQ_BIT];
	assign amplitude_demod_mixer      = demod_squelch[DEMOD_MIXER_BIT];
	assign squelch_dynamic_enable     = demod_squelch[SQUELCH_DYN_BIT];
	assign squelch_ratio_high         = demod_squelch[SQUELCH_RATIO_BIT];
	assign gain_loop_enable           = demod_squelch[GAIN_ENABLE_BIT];
	assign gain_loop_full_period      = demod_squelch[GAIN_MODE_BIT];
	assign gain_loop_reset_algorithm  = demod_squelch[GAIN_ALG_BIT];
	assign gain_loop_trigger_ratio    = demod_squelch[GAIN_RATIO_BIT];
	assign amplitude_first_stage_gain = first_stage[AMP_GAIN_MSB:AMP_GAIN_LSB];
	assign phase_first_stage_gain     = first_stage[PHASE_GAIN_MSB:PHASE_GAIN_LSB];
	assign low_frequency_input_enable = first_stage[LF_ENABLE_BIT];
	assign low_frequency_split_select = first_stage[LF_SPLIT_BIT];

	// ------------------------------------------------------------------
	// Squelch sequencing
	// ------------------------------------------------------------------
	squelch_state_t squelch_state;
	squelch_state_t next_squelch_state;
	logic [11:0]    squelch_count;
	logic [11:0]    next_squelch_count;
	logic           next_squelch_active;

	always_comb begin
		next_squelch_state  = squelch_state;
		next_squelch_count  = squelch_count;
		next_squelch_active = 1'b0;
		if (!squelch_dynamic_enable) begin
			next_squelch_state = SQUELCH_IDLE;
			next_squelch_count = 12'h000;
		end else if (tx_end_pulse) begin
			next_squelch_state = SQUELCH_WAIT;
			next_squelch_count = 12'(SQUELCH_DELAY - 1);
		end else begin
			case (squelch_state)
				SQUELCH_IDLE: begin
					next_squelch_count = 12'h000;
				end
				SQUELCH_WAIT: begin
					if (squelch_count == 12'h000) begin
						next_squelch_state  = SQUELCH_ACTIVE;
						next_squelch_active = 1'b1;
					end else begin
						next_squelch_count = squelch_count - 12'h001;
					end
				end
				SQUELCH_ACTIVE: begin
					if (mask_receive_timer == squelch_time) begin
						next_squelch_state = SQUELCH_IDLE;
					end else begin
						next_squelch_active = 1'b1;
					end
				end
				default: begin
					next_squelch_state = SQUELCH_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			squelch_state  <= SQUELCH_IDLE;
			squelch_count  <= 12'h000;
			squelch_active <= 1'b0;
		end else begin
			squelch_state  <= next_squelch_state;
			squelch_count  <= next_squelch_count;
			squelch_active <= next_squelch_active;
		end
	end

	// ------------------------------------------------------------------
	// Gain-control window
	// ------------------------------------------------------------------
	// The subcarrier pulse comes from the analog front end, so it is
	// synchronised before the edge detector sees it.
	logic       pulse_meta;
	logic       pulse_sync;
	logic       pulse_last;
	logic [3:0] pulse_count;
	logic [3:0] next_pulse_count;
	logic       next_gain_loop_active;
	logic       pulse_rise;

	always_comb begin
		pulse_rise       = pulse_sync && !pulse_last;
		next_pulse_count = pulse_count;
		if (!receive_active) begin
			next_pulse_count = 4'h0;
		end else if (pulse_rise && (pulse_count < 4'(PULSE_LIMIT))) begin
			next_pulse_count = pulse_count + 4'h1;
		end
		next_gain_loop_active = gain_loop_enable && receive_active
			&& (gain_loop_full_period || (next_pulse_count < 4'(PULSE_LIMIT)));
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pulse_meta       <= 1'b0;
			pulse_sync       <= 1'b0;
			pulse_last       <= 1'b0;
			pulse_count      <= 4'h0;
			gain_loop_active <= 1'b0;
		end else begin
			pulse_meta       <= subcarrier_pulse_pin;
			pulse_sync       <= pulse_meta;
			pulse_last       <= pulse_sync;
			pulse_count      <= next_pulse_count;
			gain_loop_active <= next_gain_loop_active;
		end
	end

endmodule : receiver_config_regs

/* core/receiver_config_pkg.sv */
// Package of constants for the receiver configuration register bank.
// Functional notes
// - Three read/write receiver configuration registers sit at indices 0Bh, 0Ch and 0Dh.
// - Bit 7 of the first register picks the amplitude (0) or phase (1) receive channel.
// - Bits 6 to 4 of the first register are the low-pass field, driven unchanged.
// - Bits 3 to 0 of the first register are four zero-setting bits, each its own output.
// - Second register bit 7 picks AM/PM or I/Q demodulation, bit 6 peak or mixer; I/Q needs bit 6 (the bank stores bit 6 as written and does not enforce it).
// - With dynamic squelch set, squelch starts 18.88 us after transmit ends and stops at timer match.
// - The squelch ratio bit picks trigger ratio 1 (clear) or 6/3 (set).
// - Gain control works on the first eight subcarrier pulses, or all of receive when set.
// - The gain-control algorithm bit picks preset (0) or reset (1).
// - Bit 0 of the second register sets gain trigger ratio 3 (clear) or 6 (set).
// - Bits 7 to 5 of the third register set the amplitude first-stage gain code.
// - Bits 4 to 2 of the third register set the phase first-stage gain code.
// - Bit 1 of the third register selects high-frequency (0) or low-frequency (1) input.
// - Bit 0 of the third register selects differential (0) or split (1) low-frequency input.
package receiver_config_pkg;

	// ------------------------------------------------------------------
	// Register indices and byte addresses
	// ------------------------------------------------------------------
	localparam logic [7:0]  FILTER_CHANNEL_INDEX = 8'h0b;
	localparam logic [7:0]  DEMOD_SQUELCH_INDEX  = 8'h0c;
	localparam logic [7:0]  FIRST_STAGE_INDEX    = 8'h0d;
	localparam logic [31:0] FILTER_CHANNEL_ADDR  = {22'h0, FILTER_CHANNEL_INDEX, 2'b00};
	localparam logic [31:0] DEMOD_SQUELCH_ADDR   = {22'h0, DEMOD_SQUELCH_INDEX, 2'b00};
	localparam logic [31:0] FIRST_STAGE_ADDR     = {22'h0, FIRST_STAGE_INDEX, 2'b00};

	// ------------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------------
	localparam logic [7:0] FILTER_CHANNEL_RESET = 8'h00;
	localparam logic [7:0] DEMOD_SQUELCH_RESET  = 8'h2c;
	localparam logic [7:0] FIRST_STAGE_RESET    = 8'hd8;

	// ------------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------------
	localparam int CHANNEL_PICK_BIT   = 7;
	localparam int LOWPASS_MSB        = 6;
	localparam int LOWPASS_LSB        = 4;
	localparam int ZERO_HIGH_BIT      = 3;
	localparam int ZERO_MID_HIGH_BIT  = 2;
	localparam int ZERO_MID_LOW_BIT   = 1;
	localparam int ZERO_LOW_BIT       = 0;
	localparam int DEMOD_IQ_BIT       = 7;
	localparam int DEMOD_MIXER_BIT    = 6;
	localparam int SQUELCH_DYN_BIT    = 5;
	localparam int SQUELCH_RATIO_BIT  = 4;
	localparam int GAIN_ENABLE_BIT    = 3;
	localparam int GAIN_MODE_BIT      = 2;
	localparam int GAIN_ALG_BIT       = 1;
	localparam int GAIN_RATIO_BIT     = 0;
	localparam int AMP_GAIN_MSB       = 7;
	localparam int AMP_GAIN_LSB       = 5;
	localparam int PHASE_GAIN_MSB     = 4;
	localparam int PHASE_GAIN_LSB     = 2;
	localparam int LF_ENABLE_BIT      = 1;
	localparam int LF_SPLIT_BIT       = 0;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam real CLOCK_PERIOD_NS      = 10.0;
	localparam real SQUELCH_DELAY_US     = 18.88;
	localparam int  SQUELCH_DELAY_CYCLES = int'(SQUELCH_DELAY_US * 1000.0 / CLOCK_PERIOD_NS);
	localparam int  GAIN_PULSE_LIMIT     = 8;

	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		SEL_NONE           = 2'b00,
		SEL_FILTER_CHANNEL = 2'b01,
		SEL_DEMOD_SQUELCH  = 2'b10,
		SEL_FIRST_STAGE    = 2'b11
	} reg_select_t;

	typedef enum logic [1:0] {
		SQUELCH_IDLE   = 2'b00,
		SQUELCH_WAIT   = 2'b01,
		SQUELCH_ACTIVE = 2'b10
	} squelch_state_t;

endpackage : receiver_config_pkg

/* verif/receiver_config_regs_properties.sv */
// Checker of bus, squelch and gain-window behaviour of the receiver configuration bank.
`timescale 1ns/1ps
module receiver_config_checker #(
	parameter int SQUELCH_DELAY = 5,
	parameter int PULSE_LIMIT   = 8
) (
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic        tx_end_pulse,
	input wire logic [7:0]  mask_receive_timer,
	input wire logic [7:0]  squelch_time,
	input wire logic        receive_active,
	input wire logic        squelch_dynamic_enable,
	input wire logic        gain_loop_enable,
	input wire logic        gain_loop_full_period,
	input wire logic        squelch_active,
	input wire logic        gain_loop_active
);
	import receiver_config_pkg::*;
	localparam int RISE = SQUELCH_DELAY + 1;
	logic        rd_q;
	logic [31:0] addr_q;
	wire         mapped = addr_q inside {FILTER_CHANNEL_ADDR, DEMOD_SQUELCH_ADDR, FIRST_STAGE_ADDR};
	// Tracks the data phase of a read so the answer is judged in its own cycle.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_q   <= 1'b0;
			addr_q <= '0;
		end else begin
			rd_q   <= hsel && htrans[1] && hready && !hwrite;
			addr_q <= haddr;
		end
	end
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	property p_bus_okay;
		$past(hresetn) |-> hreadyout && !hresp;
	endproperty
	a_bus_okay: assert property (p_bus_okay) else $error("bus stalled or not okay");
	property p_read_unmapped;
		rd_q && !mapped |-> hrdata == 32'h0000_0000;
	endproperty
	a_read_unmapped: assert property (p_read_unmapped) else $error("unmapped read not zero");
	property p_read_upper;
		rd_q |-> hrdata[31:8] == 24'h00_0000;
	endproperty
	a_read_upper: assert property (p_read_upper) else $error("read upper bits not zero");
	property p_squelch_rise;
		tx_end_pulse && squelch_dynamic_enable |-> ##[RISE:RISE] squelch_active;
	endproperty
	a_squelch_rise: assert property (p_squelch_rise) else $error("squelch start late");
	property p_squelch_stop;
		squelch_active && mask_receive_timer == squelch_time |-> ##[1:2] !squelch_active;
	endproperty
	a_squelch_stop: assert property (p_squelch_stop) else $error("squelch did not stop");
	property p_squelch_off;
		!squelch_dynamic_enable [*3] |-> !squelch_active;
	endproperty
	a_squelch_off: assert property (p_squelch_off) else $error("squelch on while off");
	property p_gain_full;
		gain_loop_enable && gain_loop_full_period && receive_active |=> gain_loop_active;
	endproperty
	a_gain_full: assert property (p_gain_full) else $error("gain window closed early");
	property p_gain_idle;
		!receive_active |=> !gain_loop_active;
	endproperty
	a_gain_idle: assert property (p_gain_idle) else $error("gain active outside rx");
endmodule : receiver_config_checker

bind receiver_config_regs receiver_config_checker #(
	.SQUELCH_DELAY(SQUELCH_DELAY), .PULSE_LIMIT(PULSE_LIMIT)
) u_checker (
	.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp,
	.tx_end_pulse, .mask_receive_timer, .squelch_time, .receive_active, .squelch_dynamic_enable,
	.gain_loop_enable, .gain_loop_full_period, .squelch_active, .gain_loop_active
);

/* verif/receiver_config_regs_tb_top.sv */
// Self-checking testbench of the receiver configuration register bank.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin \
	cmp_count++; \
	if ((got) !== (ex)) begin \
		fails++; \
		$display("[ERR] %s expected %h seen %h", nm, ex, got); \
	end \
end
module receiver_config_regs_tb_top;
	import receiver_config_pkg::*;
	localparam int SQ = 5;
	typedef struct {logic [31:0] a; logic [31:0] d;} row_t;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, tx_end_pulse = 0, receive_active = 0;
	logic subcarrier_pulse_pin = 0, hreadyout, hresp, receive_channel_pick, zero_setting_bit_high;
	logic zero_setting_bit_mid_high, zero_setting_bit_mid_low, zero_setting_bit_low;
	logic demod_iq_select, amplitude_demod_mixer, squelch_dynamic_enable, squelch_ratio_high;
	logic gain_loop_enable, gain_loop_full_period, gain_loop_reset_algorithm;
	logic gain_loop_trigger_ratio, low_frequency_input_enable, low_frequency_split_select;
	logic squelch_active, gain_loop_active;
	logic [2:0] lowpass_filter_field, amplitude_first_stage_gain, phase_first_stage_gain;
	logic [1:0] htrans = 2'b00;
	logic [31:0] haddr = '0, hwdata = '0, hrdata, q;
	logic [7:0] mask_receive_timer = 8'h00, squelch_time = 8'h40;
	int fails = 0, cmp_count = 0, n;
	logic [31:0] addrs [3] = '{FILTER_CHANNEL_ADDR, DEMOD_SQUELCH_ADDR, FIRST_STAGE_ADDR};
	logic [7:0] defs [3] = '{8'h00, 8'h2c, 8'hd8};
	row_t rows [8] = '{
		'{FILTER_CHANNEL_ADDR, 32'hFFFF_FF80},
		'{FILTER_CHANNEL_ADDR, 32'h0000_0070},
		'{FILTER_CHANNEL_ADDR, 32'hA5A5_A50A},
		'{DEMOD_SQUELCH_ADDR, 32'h0000_00C0},
		'{DEMOD_SQUELCH_ADDR, 32'h0000_0015},
		'{DEMOD_SQUELCH_ADDR, 32'h0000_000A},
		'{FIRST_STAGE_ADDR, 32'h0000_00E3},
		'{FIRST_STAGE_ADDR, 32'h0000_0068}
	};
	wire [7:0] f_filter = {receive_channel_pick, lowpass_filter_field, zero_setting_bit_high,
		zero_setting_bit_mid_high, zero_setting_bit_mid_low, zero_setting_bit_low};
	wire [7:0] f_demod = {demod_iq_select, amplitude_demod_mixer, squelch_dynamic_enable,
		squelch_ratio_high, gain_loop_enable, gain_loop_full_period, gain_loop_reset_algorithm,
		gain_loop_trigger_ratio};
	wire [7:0] f_stage = {amplitude_first_stage_gain, phase_first_stage_gain,
		low_frequency_input_enable, low_frequency_split_select};

	receiver_config_regs #(.SQUELCH_DELAY(SQ)) dut (
		.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010), .hwdata,
		.hready(hreadyout), .hrdata, .hreadyout, .hresp, .tx_end_pulse, .mask_receive_timer,
		.squelch_time, .receive_active, .subcarrier_pulse_pin, .receive_channel_pick,
		.lowpass_filter_field, .zero_setting_bit_high, .zero_setting_bit_mid_high,
		.zero_setting_bit_mid_low, .zero_setting_bit_low, .demod_iq_select, .amplitude_demod_mixer,
		.squelch_dynamic_enable, .squelch_ratio_high, .gain_loop_enable, .gain_loop_full_period,
		.gain_loop_reset_algorithm, .gain_loop_trigger_ratio, .amplitude_first_stage_gain,
		.phase_first_stage_gain, .low_frequency_input_enable, .low_frequency_split_select,
		.squelch_active, .gain_loop_active
	);

	always #5 hclk = ~hclk;

	function automatic logic [7:0] fields(input logic [31:0] a);
		return a == FILTER_CHANNEL_ADDR ? f_filter : a == DEMOD_SQUELCH_ADDR ? f_demod : f_stage;
	endfunction : fields

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : end_of_test

	task automatic tick(input int k);
		repeat (k) @(posedge hclk);
		#1;
	endtask : tick

	// Every wait is bounded so a stuck slave ends the run instead of hanging it.
	task automatic wait_ready();
		int i;
		i = 0;
		do begin
			@(posedge hclk);
			i++;
		end while (hreadyout !== 1'b1 && i < 50);
		if (i >= 50) begin
			fails++;
			end_of_test();
		end
	endtask : wait_ready

	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
		output logic [31:0] rd);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= wr;
		wait_ready();
		htrans <= 2'b00;
		hwdata <= d;
		wait_ready();
		rd = hrdata;
	endtask : bus

	// Drives one of the two pulse inputs by name, so no reference argument takes a
	// non-blocking assignment.
	task automatic pulse(input int k, input logic tx);
		@(posedge hclk);
		if (tx) begin
			tx_end_pulse <= 1'b1;
		end else begin
			subcarrier_pulse_pin <= 1'b1;
		end
		repeat (k) @(posedge hclk);
		tx_end_pulse         <= 1'b0;
		subcarrier_pulse_pin <= 1'b0;
	endtask : pulse

	initial begin
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		foreach (rows[i]) begin
			bus(1'b1, rows[i].a, rows[i].d, q);
			#1;
			`CHK("fields", rows[i].d[7:0], fields(rows[i].a))
			bus(1'b0, rows[i].a, '0, q);
			`CHK("readback", {24'h0, rows[i].d[7:0]}, q)
		end
		$display("table test done");
		@(posedge hclk);
		hresetn <= 1'b0;
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			bus(1'b0, addrs[i], '0, q);
			`CHK("reset value", {24'h0, defs[i]}, q)
			`CHK("reset fields", defs[i], fields(addrs[i]))
		end
		bus(1'b1, 32'h0000_0038, 32'hFFFF_FFFF, q);
		bus(1'b0, 32'h0000_0038, '0, q);
		`CHK("unmapped read", 32'h0, q)
		bus(1'b0, FILTER_CHANNEL_ADDR, '0, q);
		`CHK("unmapped write", 32'h0, q)
		$display("reset and unmapped tests done");
		pulse(1, 1'b1);
		n = 0;
		do begin
			tick(1);
			n++;
		end while (squelch_active !== 1'b1 && n < 50);
		`CHK("squelch delay", SQ, n)
		@(posedge hclk);
		mask_receive_timer <= squelch_time;
		tick(2);
		`CHK("squelch stop", 1'b0, squelch_active)
		@(posedge hclk);
		mask_receive_timer <= 8'h00;
		bus(1'b1, DEMOD_SQUELCH_ADDR, 32'h0000_000C, q);
		pulse(1, 1'b1);
		tick(SQ + 4);
		`CHK("squelch off", 1'b0, squelch_active)
		bus(1'b1, DEMOD_SQUELCH_ADDR, 32'h0000_0028, q);
		@(posedge hclk);
		receive_active <= 1'b1;
		repeat (7) pulse(2, 1'b0);
		tick(6);
		`CHK("gain after seven", 1'b1, gain_loop_active)
		pulse(2, 1'b0);
		tick(6);
		`CHK("gain after eight", 1'b0, gain_loop_active)
		bus(1'b1, DEMOD_SQUELCH_ADDR, 32'h0000_002C, q);
		tick(2);
		`CHK("gain full period", 1'b1, gain_loop_active)
		@(posedge hclk);
		receive_active <= 1'b0;
		tick(2);
		`CHK("gain idle", 1'b0, gain_loop_active)
		$display("squelch and gain tests done");
		end_of_test();
	end
endmodule : receiver_config_regs_tb_top
